//--- verilog/oadt_cfg.svh
// Operand addressing decode and timing constants
// Summary of operation
// - Codes 00-07 select registers; 08-1F are memory operands
// - Codes 08-0B indirect via word register 0-3; 0C-0F post-increment
// - Codes 10-17: any word register plus 8-bit displacement, 1 byte
// - Codes 18-1B: word register 0-3 plus 16-bit displacement, 2 bytes
// - Codes 1C/1D use word register 0 or 1 plus register 7 index
// - Code 1E is PC relative, 1F direct address; two extension bytes
// - Extension byte count is added to the base instruction length
// - Mode cycle term: 2,4,2,2,4,2,1 per addressing form
// - Mode accesses: 1 indirect/displacement, 2 post-inc/index, else 0
// - Registers and even internal addresses add 0; long uses 2 accesses
// - Odd internal addresses add 0/2/4 cycles with 1/2/4 accesses
// - Even 16-bit external addresses add 1/1/2 cycles, 1/1/2 accesses
// - Odd 16-bit external addresses add 1/4/8 cycles, 1/2/4 accesses
// - An 8-bit external bus adds 1/4/8 cycles with 1/2/4 accesses
// - External wait cycles lengthen the instruction past its count
// - Fetch costs 2 per word internal, 3 per word ext16, 3 per byte ext8
// - Memory forms: base plus mode term plus correction; exchange twice
// - Long register byte load: 3 bytes, 10 cycles, 2 register accesses
// - Word register word load: 2 bytes, 5 cycles, 1 register access
// - Byte exchange with a register: 7 cycles, 4 accesses, flags kept
// - Byte loads zero-fill or sign-extend the upper byte of the low half
// - Loads other than long copy the old low half into the high half first
`ifndef OADT_CFG_SVH
`define OADT_CFG_SVH

`define OADT_CODE_IND      5'h08
`define OADT_CODE_POSTINC  5'h0C
`define OADT_CODE_SHORT_DISPLACEMENT    5'h10
`define OADT_CODE_LONG_DISPLACEMENT   5'h18
`define OADT_CODE_IDX0     5'h1C
`define OADT_CODE_IDX1     5'h1D
`define OADT_CODE_PCREL    5'h1E
`define OADT_CODE_DIRECT   5'h1F

`define OADT_EXT_NONE      3'h0
`define OADT_EXT_ONE       3'h1
`define OADT_EXT_TWO       3'h2

`define OADT_A_IND         7'h02
`define OADT_A_POSTINC     7'h04
`define OADT_A_DISP        7'h02
`define OADT_A_IDX         7'h04
`define OADT_A_PCREL       7'h02
`define OADT_A_DIRECT      7'h01
`define OADT_RG_ONE        3'h1
`define OADT_RG_TWO        3'h2
`define OADT_RG_NONE       3'h0

`define OADT_C_ZERO        4'h0
`define OADT_C_ONE         4'h1
`define OADT_C_TWO         4'h2
`define OADT_C_FOUR        4'h4
`define OADT_C_EIGHT       4'h8
`define OADT_N_ONE         3'h1
`define OADT_N_TWO         3'h2
`define OADT_N_FOUR        3'h4

`define OADT_LEN_EA        3'h2
`define OADT_LEN_RLD8      3'h3
`define OADT_LEN_RWD8      3'h2
`define OADT_BASE_LD_EAR   7'h02
`define OADT_BASE_LD_EAM   7'h03
`define OADT_BASE_LDL_EAR  7'h04
`define OADT_BASE_LDL_EAM  7'h05
`define OADT_BASE_XCH_EAR  7'h07
`define OADT_BASE_XCH_EAM  7'h09
`define OADT_BASE_RLD8     7'h0A
`define OADT_BASE_RWD8     7'h05
`define OADT_RG_LD_EAR     3'h1
`define OADT_RG_LDL_EAR    3'h2
`define OADT_RG_XCH_EAR    3'h4
`define OADT_RG_XCH_EAM    3'h2
`define OADT_RG_RLD8       3'h2
`define OADT_RG_RWD8       3'h1

`define OADT_FETCH_INT     7'h02
`define OADT_FETCH_EXT16   7'h03
`define OADT_FETCH_EXT8    7'h03

`endif

//--- verilog/oadt_pkg.sv
// Operand addressing decode and timing types
`default_nettype none
package oadt_pkg;
  typedef enum logic [2:0] {
    mode_reg, mode_ind, mode_postinc, mode_short_displacement,
    mode_long_displacement, mode_index, mode_pcrel, mode_direct
  } oadt_mode_t;
  typedef enum logic [1:0] {sz_byte, sz_word, sz_long} oadt_size_t;
  typedef enum logic [1:0] {
    loc_int_reg, loc_int_mem, loc_ext16, loc_ext8
  } oadt_loc_t;
  typedef enum logic [3:0] {
    cls_ld_byte, cls_ld_sx, cls_ld_word, cls_ld_long,
    cls_ld_rl_d8, cls_ld_rw_d8, cls_xch_byte, cls_xch_word
  } oadt_class_t;
  typedef enum logic {st_idle, st_run} oadt_state_t;
endpackage
`default_nettype wire

//--- verilog/oadt_mode_dec.sv
// Operand field decoder: mode, extension bytes, cycle and access terms
`include "oadt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module oadt_mode_dec (
  // Operand field
  input  wire logic [4:0]          ea_code,
  // Decoded terms
  output oadt_pkg::oadt_mode_t     mode,
  output logic [2:0]               ext_bytes,
  output logic [6:0]               mode_cyc,
  output logic [2:0]               mode_rg,
  output logic [2:0]               base_reg
);
  always_comb begin
    mode      = oadt_pkg::mode_reg;
    ext_bytes = `OADT_EXT_NONE;
    mode_cyc  = 7'h00;
    mode_rg   = `OADT_RG_NONE;
    base_reg  = ea_code[2:0];
    if (ea_code < `OADT_CODE_IND) begin
      mode = oadt_pkg::mode_reg;
    end else if (ea_code < `OADT_CODE_POSTINC) begin
      mode     = oadt_pkg::mode_ind;
      base_reg = {1'b0, ea_code[1:0]};
      mode_cyc = `OADT_A_IND;
      mode_rg  = `OADT_RG_ONE;
    end else if (ea_code < `OADT_CODE_SHORT_DISPLACEMENT) begin
      mode     = oadt_pkg::mode_postinc;
      base_reg = {1'b0, ea_code[1:0]};
      mode_cyc = `OADT_A_POSTINC;
      mode_rg  = `OADT_RG_TWO;
    end else if (ea_code < `OADT_CODE_LONG_DISPLACEMENT) begin
      mode      = oadt_pkg::mode_short_displacement;
      ext_bytes = `OADT_EXT_ONE;
      mode_cyc  = `OADT_A_DISP;
      mode_rg   = `OADT_RG_ONE;
    end else if (ea_code < `OADT_CODE_IDX0) begin
      mode      = oadt_pkg::mode_long_displacement;
      base_reg  = {1'b0, ea_code[1:0]};
      ext_bytes = `OADT_EXT_TWO;
      mode_cyc  = `OADT_A_DISP;
      mode_rg   = `OADT_RG_ONE;
    end else if (ea_code <= `OADT_CODE_IDX1) begin
      mode     = oadt_pkg::mode_index;
      base_reg = {2'b00, ea_code[0]};
      mode_cyc = `OADT_A_IDX;
      mode_rg  = `OADT_RG_TWO;
    end else if (ea_code == `OADT_CODE_PCREL) begin
      mode      = oadt_pkg::mode_pcrel;
      ext_bytes = `OADT_EXT_TWO;
      mode_cyc  = `OADT_A_PCREL;
    end else begin
      mode      = oadt_pkg::mode_direct;
      ext_bytes = `OADT_EXT_TWO;
      mode_cyc  = `OADT_A_DIRECT;
    end
  end
endmodule // oadt_mode_dec
`default_nettype wire

//--- verilog/oadt_corr.sv
// Size and alignment correction for operand accesses
`include "oadt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module oadt_corr (
  // Operand attributes
  input  wire oadt_pkg::oadt_size_t size,
  input  wire oadt_pkg::oadt_loc_t  loc,
  input  wire logic            odd,
  // Correction
  output logic [3:0]           corr_cyc,
  output logic [2:0]           corr_acc
);
  logic is_long;
  logic is_byte;
  assign is_long = (size == oadt_pkg::sz_long);
  assign is_byte = (size == oadt_pkg::sz_byte);
  always_comb begin
    corr_cyc = `OADT_C_ZERO;
    corr_acc = is_long ? `OADT_N_TWO : `OADT_N_ONE;
    unique case (loc)
      oadt_pkg::loc_int_reg: begin
      end
      oadt_pkg::loc_int_mem: begin
        if (odd && !is_byte) begin
          corr_cyc = is_long ? `OADT_C_FOUR : `OADT_C_TWO;
          corr_acc = is_long ? `OADT_N_FOUR : `OADT_N_TWO;
        end
      end
      oadt_pkg::loc_ext16: begin
        if (odd && !is_byte) begin
          corr_cyc = is_long ? `OADT_C_EIGHT : `OADT_C_FOUR;
          corr_acc = is_long ? `OADT_N_FOUR : `OADT_N_TWO;
        end else begin
          corr_cyc = is_long ? `OADT_C_TWO : `OADT_C_ONE;
        end
      end
      oadt_pkg::loc_ext8: begin
        corr_cyc = is_byte ? `OADT_C_ONE :
                   (is_long ? `OADT_C_EIGHT : `OADT_C_FOUR);
        corr_acc = is_byte ? `OADT_N_ONE :
                   (is_long ? `OADT_N_FOUR : `OADT_N_TWO);
      end
    endcase
  end
endmodule // oadt_corr
`default_nettype wire

//--- verilog/oadt_top.sv
// Operand addressing decoder with cycle counting and transfer effects
`include "oadt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module oadt_top (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                nrst,
  input  wire logic                clk_en,
  // Instruction request
  input  wire logic                req_valid,
  input  wire oadt_pkg::oadt_class_t req_class,
  input  wire logic [4:0]          ea_code,
  input  wire oadt_pkg::oadt_loc_t operand_loc,
  input  wire logic                addr_odd,
  input  wire oadt_pkg::oadt_loc_t fetch_loc,
  input  wire logic [31:0]         operand_data,
  input  wire logic [15:0]         reg_in,
  // External bus wait
  input  wire logic                bus_wait,
  // Timing results
  output logic                     busy_q,
  output logic                     done_q,
  output logic [2:0]               instr_len_q,
  output logic [2:0]               ext_bytes_q,
  output logic [6:0]               exec_cyc_q,
  output logic [6:0]               mode_cyc_q,
  output logic [2:0]               reg_acc_q,
  output logic [2:0]               bus_acc_q,
  output logic                     is_mem_q,
  output logic [2:0]               base_reg_q,
  // Data results
  output logic [31:0]              acc_q,
  output logic                     flag_n_q,
  output logic                     flag_z_q,
  output logic                     xch_we_q,
  output logic [15:0]              reg_wr_q,
  output logic [15:0]              mem_wr_q
);
  ////////////////////////////////////////////////////////////////////////
  oadt_pkg::oadt_mode_t  mode;
  oadt_pkg::oadt_size_t  size;
  oadt_pkg::oadt_loc_t   loc;
  oadt_pkg::oadt_class_t cls_q;
  oadt_pkg::oadt_state_t state_q;
  logic [2:0]  ext_bytes;
  logic [6:0]  mode_cyc;
  logic [2:0]  mode_rg;
  logic [2:0]  base_reg;
  logic [3:0]  corr_cyc;
  logic [2:0]  corr_acc;
  logic        fixed_form;
  logic        is_mem;
  logic        is_xch;
  logic [2:0]  len_d;
  logic [2:0]  len_t;
  logic [6:0]  base_d;
  logic [2:0]  rg_d;
  logic [6:0]  corr_d;
  logic [2:0]  acc_n_d;
  logic [6:0]  fetch_d;
  logic [6:0]  exec_d;
  logic [6:0]  cnt_q;
  logic        ext_q;
  logic        stall;
  logic        fire;
  logic        last;
  logic [31:0] data_q;
  logic [15:0] regv_q;
  logic [31:0] acc_d;

  assign fire = clk_en && req_valid && (state_q == oadt_pkg::st_idle);
  assign fixed_form = (req_class == oadt_pkg::cls_ld_rl_d8) ||
                      (req_class == oadt_pkg::cls_ld_rw_d8);
  assign is_xch = (req_class == oadt_pkg::cls_xch_byte) ||
                  (req_class == oadt_pkg::cls_xch_word);
  assign is_mem = fixed_form || (mode != oadt_pkg::mode_reg);
  assign loc = is_mem ? operand_loc : oadt_pkg::loc_int_reg;

  ////////////////////////////////////////////////////////////////////////
  oadt_mode_dec u_dec (
    .ea_code   (ea_code),
    .mode      (mode),
    .ext_bytes (ext_bytes),
    .mode_cyc  (mode_cyc),
    .mode_rg   (mode_rg),
    .base_reg  (base_reg)
  );

  oadt_corr u_corr (
    .size     (size),
    .loc      (loc),
    .odd      (addr_odd),
    .corr_cyc (corr_cyc),
    .corr_acc (corr_acc)
  );

  ////////////////////////////////////////////////////////////////////////
  // Base figures per instruction form
  always_comb begin
    size   = oadt_pkg::sz_byte;
    len_d  = `OADT_LEN_EA;
    base_d = is_mem ? `OADT_BASE_LD_EAM : `OADT_BASE_LD_EAR;
    rg_d   = is_mem ? mode_rg : `OADT_RG_LD_EAR;
    unique case (req_class)
      oadt_pkg::cls_ld_byte, oadt_pkg::cls_ld_sx: begin
      end
      oadt_pkg::cls_ld_word: begin
        size = oadt_pkg::sz_word;
      end
      oadt_pkg::cls_ld_long: begin
        size   = oadt_pkg::sz_long;
        base_d = is_mem ? `OADT_BASE_LDL_EAM : `OADT_BASE_LDL_EAR;
        rg_d   = is_mem ? mode_rg : `OADT_RG_LDL_EAR;
      end
      oadt_pkg::cls_ld_rl_d8: begin
        len_d  = `OADT_LEN_RLD8;
        base_d = `OADT_BASE_RLD8;
        rg_d   = `OADT_RG_RLD8;
      end
      oadt_pkg::cls_ld_rw_d8: begin
        size   = oadt_pkg::sz_word;
        len_d  = `OADT_LEN_RWD8;
        base_d = `OADT_BASE_RWD8;
        rg_d   = `OADT_RG_RWD8;
      end
      oadt_pkg::cls_xch_byte, oadt_pkg::cls_xch_word: begin
        if (req_class == oadt_pkg::cls_xch_word) begin
          size = oadt_pkg::sz_word;
        end
        base_d = is_mem ? `OADT_BASE_XCH_EAM : `OADT_BASE_XCH_EAR;
        rg_d   = is_mem ? 3'(mode_rg + `OADT_RG_XCH_EAM)
                        : `OADT_RG_XCH_EAR;
      end
      default: begin
      end
    endcase
  end

  // Totals
  always_comb begin
    len_t = len_d;
    if (!fixed_form && is_mem) begin
      len_t = 3'(len_d + ext_bytes);
    end
    corr_d  = is_xch ? 7'({corr_cyc, 1'b0}) : 7'(corr_cyc);
    acc_n_d = is_xch ? 3'({corr_acc[1:0], 1'b0}) : corr_acc;
    unique case (fetch_loc)
      oadt_pkg::loc_ext16:
        fetch_d = 7'(`OADT_FETCH_EXT16 * 7'((len_t + 3'h1) >> 1));
      oadt_pkg::loc_ext8:
        fetch_d = 7'(`OADT_FETCH_EXT8 * 7'(len_t));
      default:
        fetch_d = 7'(`OADT_FETCH_INT * 7'((len_t + 3'h1) >> 1));
    endcase
    exec_d = 7'(base_d + corr_d + fetch_d);
    if (!fixed_form && is_mem) begin
      exec_d = 7'(exec_d + mode_cyc);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Captured request figures
  always_ff @(posedge clock) begin
    if (!nrst) begin
      instr_len_q <= 3'h0;
      ext_bytes_q <= 3'h0;
      exec_cyc_q  <= 7'h00;
      mode_cyc_q  <= 7'h00;
      reg_acc_q   <= 3'h0;
      bus_acc_q   <= 3'h0;
      is_mem_q    <= 1'b0;
      base_reg_q  <= 3'h0;
      cls_q       <= oadt_pkg::cls_ld_byte;
      ext_q       <= 1'b0;
      data_q      <= 32'h0000_0000;
      regv_q      <= 16'h0000;
    end else if (fire) begin
      instr_len_q <= len_t;
      ext_bytes_q <= (is_mem && !fixed_form) ? ext_bytes : 3'h0;
      exec_cyc_q  <= exec_d;
      mode_cyc_q  <= (is_mem && !fixed_form) ? mode_cyc : 7'h00;
      reg_acc_q   <= rg_d;
      bus_acc_q   <= acc_n_d;
      is_mem_q    <= is_mem;
      base_reg_q  <= base_reg;
      cls_q       <= req_class;
      ext_q       <= (loc == oadt_pkg::loc_ext16) ||
                     (loc == oadt_pkg::loc_ext8) ||
                     (fetch_loc != oadt_pkg::loc_int_mem);
      data_q      <= operand_data;
      regv_q      <= reg_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // waits stretch the count
  assign stall = ext_q && bus_wait;
  assign last  = (cnt_q == 7'h01) && !stall;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q <= oadt_pkg::st_idle;
      cnt_q   <= 7'h00;
    end else if (clk_en) begin
      unique case (state_q)
        oadt_pkg::st_idle: begin
          if (fire) begin
            state_q <= oadt_pkg::st_run;
            cnt_q   <= exec_d;
          end
        end
        oadt_pkg::st_run: begin
          if (last) begin
            state_q <= oadt_pkg::st_idle;
          end
          if (!stall) begin
            cnt_q <= 7'(cnt_q - 7'h01);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      busy_q <= fire || (busy_q && !last);
      done_q <= busy_q && last;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulator result
  always_comb begin
    acc_d = acc_q;
    unique case (cls_q)
      oadt_pkg::cls_ld_byte, oadt_pkg::cls_ld_rl_d8:
        acc_d = {acc_q[15:0], 8'h00, data_q[7:0]};
      oadt_pkg::cls_ld_sx:
        acc_d = {acc_q[15:0], {8{data_q[7]}}, data_q[7:0]};
      oadt_pkg::cls_ld_word, oadt_pkg::cls_ld_rw_d8:
        acc_d = {acc_q[15:0], data_q[15:0]};
      oadt_pkg::cls_ld_long:
        acc_d = data_q;
      default:
        acc_d = acc_q;
    endcase
  end

  function automatic logic is_xch_q();
    return (cls_q == oadt_pkg::cls_xch_byte) ||
           (cls_q == oadt_pkg::cls_xch_word);
  endfunction

  always_ff @(posedge clock) begin
    if (!nrst) begin
      acc_q    <= 32'h0000_0000;
      flag_n_q <= 1'b0;
      flag_z_q <= 1'b0;
    end else if (clk_en && busy_q && last && !is_xch_q()) begin
      acc_q <= acc_d;
      if (cls_q == oadt_pkg::cls_ld_long) begin
        flag_n_q <= acc_d[31];
        flag_z_q <= (acc_d == 32'h0000_0000);
      end else begin
        flag_n_q <= acc_d[15];
        flag_z_q <= (acc_d[15:0] == 16'h0000);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      xch_we_q <= 1'b0;
      reg_wr_q <= 16'h0000;
      mem_wr_q <= 16'h0000;
    end else if (clk_en) begin
      xch_we_q <= busy_q && last && is_xch_q();
      if (busy_q && last && is_xch_q()) begin
        if (cls_q == oadt_pkg::cls_xch_byte) begin
          reg_wr_q <= {8'h00, data_q[7:0]};
          mem_wr_q <= {8'h00, regv_q[7:0]};
        end else begin
          reg_wr_q <= data_q[15:0];
          mem_wr_q <= regv_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  reg_direct_a: assert property (
    fire && !fixed_form && ea_code < 5'h08 |=> !is_mem_q)
    else $error("register code charged as memory");
  postinc_terms_a: assert property (
    fire && !fixed_form && ea_code inside {[5'h0C:5'h0F]}
    |=> mode_cyc_q == 7'h04 && ext_bytes_q == 3'h0)
    else $error("post-increment terms wrong");
  short_displacement_len_a: assert property (
    fire && req_class == oadt_pkg::cls_ld_byte &&
    ea_code inside {[5'h10:5'h17]} |=> instr_len_q == 3'h3)
    else $error("short displacement length wrong");
  long_displacement_ext_a: assert property (
    fire && !fixed_form && ea_code inside {[5'h18:5'h1B]}
    |=> ext_bytes_q == 3'h2 && base_reg_q == $past(ea_code[2:0]) - 3'h0)
    else $error("long displacement extension wrong");
  rl_disp_load_a: assert property (
    fire && req_class == oadt_pkg::cls_ld_rl_d8
    |=> instr_len_q == 3'h3 && reg_acc_q == 3'h2)
    else $error("long register load figures wrong");
  rw_disp_load_a: assert property (
    fire && req_class == oadt_pkg::cls_ld_rw_d8
    |=> instr_len_q == 3'h2 && reg_acc_q == 3'h1)
    else $error("word register load figures wrong");
  wait_stretch_a: assert property (
    busy_q && (stall || !clk_en) |=> cnt_q == $past(cnt_q))
    else $error("count moved during wait");
  xch_flags_a: assert property (
    xch_we_q |-> $stable(flag_n_q) && $stable(flag_z_q) && $stable(acc_q))
    else $error("exchange touched flags");
  zero_fill_a: assert property (
    done_q && $past(busy_q) && cls_q == oadt_pkg::cls_ld_byte
    |-> acc_q[15:8] == 8'h00)
    else $error("byte load not zero filled");
  high_copy_a: assert property (
    done_q && $past(busy_q) && cls_q == oadt_pkg::cls_ld_word
    |-> acc_q[31:16] == $past(acc_q[15:0]))
    else $error("old low half not copied up");

  xch_mem_c: cover property (fire && is_xch && is_mem);
  wait_done_c: cover property (stall ##[1:20] done_q);
  long_odd_c: cover property (fire && req_class == oadt_pkg::cls_ld_long
                              && addr_odd);
endmodule // oadt_top
`default_nettype wire

//--- tb/oadt_bus_model.sv
// Far-side bus model: ready wait cycles per instruction
`timescale 1ns/1ps
`default_nettype none
module oadt_bus_model (
  // Clock and status
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       busy_q,
  // Wait burst length
  input  wire logic [1:0] wait_len,
  // Ready stretch
  output logic            bus_wait
);
  int cnt;
  // ready wait insertion
  // One burst per instruction so the stretch is exact
  always @(negedge clock) begin
    if (!nrst || !busy_q) begin
      cnt = 0;
      bus_wait <= 1'b0;
    end else begin
      bus_wait <= (cnt < wait_len);
      cnt = cnt + 1;
    end
  end
endmodule // oadt_bus_model
`default_nettype wire

//--- tb/operand_address_decode_timing_test.sv
// Self-checking bench: figures and data effects against a model
`timescale 1ns/1ps
`default_nettype none
module operand_address_decode_timing_test;
  logic                  clock, nrst, clk_en, req_valid, addr_odd;
  logic                  bus_wait, busy_q, done_q, is_mem_q, xch_we_q;
  logic                  flag_n_q, flag_z_q, fn, fz;
  oadt_pkg::oadt_class_t req_class;
  oadt_pkg::oadt_loc_t   operand_loc, fetch_loc;
  logic [4:0]            ea_code;
  logic [1:0]            wait_len;
  logic [2:0]            instr_len_q, ext_bytes_q, reg_acc_q;
  logic [2:0]            bus_acc_q, base_reg_q;
  logic [6:0]            exec_cyc_q, mode_cyc_q;
  logic [15:0]           reg_in, reg_wr_q, mem_wr_q;
  logic [31:0]           operand_data, acc_q, acc_m, lfsr;
  int                    fail_count, checked;

  oadt_top oadt_top_inst (
    .clock, .nrst, .clk_en, .req_valid, .req_class, .ea_code,
    .operand_loc, .addr_odd, .fetch_loc, .operand_data, .reg_in,
    .bus_wait, .busy_q, .done_q, .instr_len_q, .ext_bytes_q,
    .exec_cyc_q, .mode_cyc_q, .reg_acc_q, .bus_acc_q, .is_mem_q,
    .base_reg_q, .acc_q, .flag_n_q, .flag_z_q, .xch_we_q,
    .reg_wr_q, .mem_wr_q
  );
  oadt_bus_model oadt_bus_model_inst (
    .clock, .nrst, .busy_q, .wait_len, .bus_wait
  );

  always #12.5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Counts: %0d compared, %0d mismatched", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] l);
    return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Classes: 0-3 loads, 4/5 fixed displacement loads, 6/7 exchanges
  task automatic run(input int c, input int e);
    int sz, fix, x, mem, eb, mt, cc, ca, len, fch, n, ext, far, br, rg;
    logic [1:0]  lc, fl;
    logic [31:0] d, g;
    logic [15:0] lo, ri;
    logic        od;
    lfsr = nxt(lfsr);
    d = (lfsr[6:5] == 2'h0) ? 32'h0 : {lfsr[7:0], lfsr[31:8]};
    ri = lfsr[31:16];
    fl = (lfsr[4:3] == 2'h0) ? 2'h1 : lfsr[4:3];
    @(negedge clock);
    req_class = oadt_pkg::oadt_class_t'(c);
    ea_code = e[4:0];
    operand_loc = oadt_pkg::oadt_loc_t'(lfsr[1:0]);
    addr_odd = lfsr[2];
    fetch_loc = oadt_pkg::oadt_loc_t'(fl);
    operand_data = d;
    reg_in = ri;
    wait_len = lfsr[8:7];
    req_valid = 1'b1;
    @(negedge clock);
    // Held request while busy must be ignored
    req_class = oadt_pkg::oadt_class_t'({1'b0, lfsr[11:9]});
    ea_code = lfsr[16:12];
    operand_data = ~d;
    n = 0;
    g = lfsr;
    // Enable drops freeze the count; waits all land in the first 4 edges
    while (done_q !== 1'b1 && n < 200) begin
      g = nxt(g);
      clk_en = (n < 4) || g[0] || g[1];
      @(negedge clock);
      n += clk_en;
    end
    clk_en = 1'b1;
    req_valid = 1'b0;
    sz = (c == 2 || c == 5 || c == 7) ? 1 : (c == 3) ? 2 : 0;
    fix = (c == 4 || c == 5);
    x = (c >= 6);
    mem = (!fix && e >= 8);
    eb = (e < 16 || e == 28 || e == 29) ? 0 : (e < 24) ? 1 : 2;
    mt = (e >= 12 && e < 16 || e == 28 || e == 29) ? 4 : (e == 31) ? 1 : 2;
    lc = (mem || fix) ? lfsr[1:0] : 2'h0;
    od = lfsr[2] && lc != 2'h0;
    far = (lc == 2'h3 || lc == 2'h2 && od);
    cc = od ? 2 * sz : 0;
    if (lc == 2'h2)
      cc = (sz == 2) ? 2 : 1;
    if (far)
      cc = sz ? 4 * sz : 1;
    ca = (far || od) ? 1 << sz : (sz == 2) ? 2 : 1;
    len = fix ? ((c == 4) ? 3 : 2) : 2 + eb;
    fch = (fl == 2'h3) ? 3 * len : ((fl == 2'h2) ? 3 : 2) * ((len + 1) / 2);
    ext = (fl != 2'h1 || lc[1]);
    cc = (fix ? ((c == 4) ? 10 : 5) : x ? 7 : (sz == 2) ? 4 : 2)
         + mem * (1 + x + mt) + cc * (1 + x) + fch;
    br = (e >= 16 && e < 24) ? e % 8 : (e >= 28) ? e - 28 : e % 4;
    check(instr_len_q, len);
    check(exec_cyc_q, cc);
    check(n, cc + (ext ? wait_len : 0));
    rg = fix ? ((c == 4) ? 2 : 1) : x ? 4 : (sz == 2) ? 2 : 1;
    if (mem)
      rg = ((mt == 4) ? 2 : (e >= 30) ? 0 : 1) + 2 * x;
    check(reg_acc_q, rg);
    check(bus_acc_q, ca * (1 + x));
    check(xch_we_q, x);
    if (!fix)
      check(ext_bytes_q, eb);
    if (!fix)
      check(is_mem_q, mem);
    if (mem)
      check(mode_cyc_q, mt);
    if (mem && e < 30)
      check(base_reg_q, br);
    lo = (c == 1) ? {{8{d[7]}}, d[7:0]} : sz ? d[15:0] : {8'h00, d[7:0]};
    if (x) begin
      check(reg_wr_q, sz ? d[15:0] : {8'h00, d[7:0]});
      check(mem_wr_q, sz ? ri : {8'h00, ri[7:0]});
    end else begin
      acc_m = (sz == 2) ? d : {acc_m[15:0], lo};
      fn = (sz == 2) ? d[31] : lo[15];
      fz = (sz == 2) ? d == 32'h0 : lo == 16'h0;
    end
    check(acc_q, acc_m);
    check(flag_n_q, fn);
    check(flag_z_q, fz);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    req_valid = 1'b0;
    req_class = oadt_pkg::cls_ld_byte;
    ea_code = 5'h00;
    operand_loc = oadt_pkg::loc_int_reg;
    addr_odd = 1'b0;
    fetch_loc = oadt_pkg::loc_int_mem;
    operand_data = 32'h0;
    reg_in = 16'h0;
    wait_len = 2'h0;
    acc_m = 32'h0;
    fn = 1'b0;
    fz = 1'b0;
    lfsr = 32'h0001661F;
    fail_count = 0;
    checked = 0;
    repeat (20) @(negedge clock);
    check(busy_q, 1'b0);
    check(acc_q, 32'h0);
    nrst = 1'b1;
    $display("Test done: reset");
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 8; c++) begin
        for (int e = 0; e < 32; e++) begin
          run(c, e);
        end
      end
    end
    $display("Test done: class and code sweep");
    print_verdict();
  end

  // Sweep needs about 10k cycles; 40k leaves margin for waits
  initial begin
    #1000000;
    fail_count++;
    print_verdict();
  end
endmodule // operand_address_decode_timing_test
`default_nettype wire
